// File: onehot_fsm.sv
// Function
// - The state register is built with either a synchronous or an asynchronous reset.
// - A build option makes the reset input active high when on and active low when off.
// - With output registering on, every state output comes from a flip-flop.
// - With default hold on and no condition out of the current state true, the state stays.
// - Negation binds first, then each term's comparison; AND or OR joins the two terms last.
// - Each entry names source, condition and destination, and is taken from its source.
// - The state is one-hot; an output without an enabled action equals its state bit.
// - With no action enabled, the current state's output is 1 and every other output is 0.
// - By default there are five inputs and five states with one output per state.
// - One state is the reset state and reset forces the machine into it.
// - When several conditions out of a state hold, the earliest entry wins.
// - A condition that is the constant one is taken from its source unless an earlier entry out of that source holds.
// - A table with a state lacking an outgoing transition is refused and not run.
// - Each output may carry its own action condition that gives its value.
// - A valid build has one reset state, a reset input and at least two states.
`include "onehot_fsm_cfg.svh"
`default_nettype none
module onehot_fsm #(
  parameter int N_INPUTS          = 5,
  parameter int N_STATES          = 5,
  parameter int N_TRANS           = 8,
  parameter int IN_W              = 26,
  parameter int RESET_STATE       = 0,
  parameter bit SYNC_RESET        = 1'b0,
  parameter bit RESET_ACTIVE_HIGH = 1'b1,
  parameter bit REG_OUTPUTS       = 1'b0,
  parameter bit DEFAULT_HOLD      = 1'b1
) (
  input  wire logic                          hclk,      // Bus and machine clock.
  input  wire logic                          hresetn,   // Bus reset, async, active low.
  input  wire logic                          hsel,      // Slave select.
  input  wire logic [31:0]                   haddr,     // Byte address.
  input  wire logic [1:0]                    htrans,    // Transfer type.
  input  wire logic                          hwrite,    // Write when high.
  input  wire logic [2:0]                    hsize,     // Transfer size.
  input  wire logic [31:0]                   hwdata,    // Write data.
  input  wire logic                          hready,    // Bus ready.
  output logic                               hreadyout, // Slave ready.
  output logic                               hresp,     // Always OKAY.
  output logic [31:0]                        hrdata,    // Read data.
  input  wire logic                          fsm_rst,   // Machine reset, polarity set.
  input  wire logic [N_INPUTS-1:0][IN_W-1:0] fsm_in,    // Integer inputs.
  output logic [N_STATES-1:0]                state_out  // One output per state.
);
  import onehot_fsm_pkg::*;

  localparam logic [N_STATES-1:0] RST_ONEHOT = N_STATES'(1) << RESET_STATE;
  localparam logic [N_STATES-1:0] ONE_BIT    = N_STATES'(1);

  // A machine that could never be valid is stopped at elaboration.
  if (N_STATES < 2 || N_STATES > 8 || RESET_STATE >= N_STATES) begin : g_bad_cfg
    $error("state count or reset state out of range");
  end

  logic                 run_r;
  logic [7:0]           act_en_r;
  term_t                act_r [8];
  trans_t               tr_r [N_TRANS];
  logic [N_STATES-1:0]  state_r;
  logic [N_STATES-1:0]  state_nxt;
  logic [N_STATES-1:0]  out_comb;
  logic                 wr_pend_r;
  logic [7:0]           wr_addr_r;
  logic [31:0]          hrdata_r;
  logic [31:0]          rd_nxt;
  logic [N_TRANS-1:0]   fire;
  logic [N_STATES-1:0]  act_hit;
  logic                 sel_found;
  logic [2:0]           sel_dst;
  logic                 cfg_valid;
  logic [N_STATES-1:0]  has_out;
  logic                 bad_entry;

  wire logic rst_act = RESET_ACTIVE_HIGH ? fsm_rst : ~fsm_rst;
  wire logic go      = run_r & cfg_valid;
  wire logic take    = hsel & hready & htrans[1];

  // Bus slave: zero wait states, every answer OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  // Address phase capture; only whole-word writes are accepted.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_pend_r <= take & hwrite & (hsize == 3'b010);
      wr_addr_r <= haddr[7:0];
      if (take && !hwrite) begin
        hrdata_r <= rd_nxt;
      end
    end
  end

  wire logic wr_ctrl   = wr_pend_r && (wr_addr_r == `CTRL_OFS);
  wire logic wr_act_en = wr_pend_r && (wr_addr_r == `ACT_EN_OFS);

  // Control and action-enable registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r    <= `RUN_RST;
      act_en_r <= `ACT_EN_RST;
    end else begin
      if (wr_ctrl) begin
        run_r <= hwdata[`CTRL_RUN_BIT];
      end
      if (wr_act_en) begin
        act_en_r <= hwdata[7:0];
      end
    end
  end

  // Per-output action terms, one word each.
  for (genvar k = 0; k < 8; k++) begin : g_act
    localparam logic [7:0] OFS = 8'(`ACT_BASE + 4 * k);
    wire logic wr_this = wr_pend_r && (wr_addr_r == OFS);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        act_r[k] <= `TERM_RST;
      end else if (wr_this) begin
        act_r[k] <= hwdata[15:0];
      end
    end
  end

  // Transition table: word 0 holds routing, word 1 holds both terms.
  for (genvar i = 0; i < N_TRANS; i++) begin : g_tr
    localparam logic [7:0] OFS0 = 8'(`TRANS_BASE + `TRANS_STRIDE * i);
    localparam logic [7:0] OFS1 = 8'(`TRANS_BASE + `TRANS_STRIDE * i + 4);
    wire logic wr0 = wr_pend_r && (wr_addr_r == OFS0);
    wire logic wr1 = wr_pend_r && (wr_addr_r == OFS1);
    logic h0;
    logic h1;
    logic src_ok;

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        tr_r[i] <= '0;
      end else begin
        if (wr0) begin
          tr_r[i].valid   <= hwdata[`TR_VALID_BIT];
          tr_r[i].join_or <= hwdata[`TR_JOIN_BIT];
          tr_r[i].src     <= hwdata[`TR_SRC_LSB +: 3];
          tr_r[i].dst     <= hwdata[`TR_DST_LSB +: 3];
        end
        if (wr1) begin
          tr_r[i].t0 <= hwdata[15:0];
          tr_r[i].t1 <= hwdata[`TR_T1_LSB +: 16];
        end
      end
    end

    cond_term #(.N_INPUTS(N_INPUTS), .IN_W(IN_W)) u_t0 (
      .term    (tr_r[i].t0),
      .in_vals (fsm_in),
      .hit     (h0)
    );
    cond_term #(.N_INPUTS(N_INPUTS), .IN_W(IN_W)) u_t1 (
      .term    (tr_r[i].t1),
      .in_vals (fsm_in),
      .hit     (h1)
    );

    // The two terms share one level and combine left to right.
    assign src_ok  = int'(tr_r[i].src) < N_STATES;
    assign fire[i] = tr_r[i].valid && src_ok && state_r[tr_r[i].src] &&
                     (tr_r[i].join_or ? (h0 | h1) : (h0 & h1));
  end

  // Earliest entry wins: the loop runs backwards so index 0 is written last.
  always_comb begin
    sel_found = 1'b0;
    sel_dst   = 3'b000;
    for (int i = N_TRANS - 1; i >= 0; i--) begin
      if (fire[i]) begin
        sel_found = 1'b1;
        sel_dst   = tr_r[i].dst;
      end
    end
  end

  // Table check: every state needs an exit and every valid entry names real states.
  always_comb begin
    has_out   = '0;
    bad_entry = 1'b0;
    for (int i = 0; i < N_TRANS; i++) begin
      if (tr_r[i].valid) begin
        if (int'(tr_r[i].src) >= N_STATES || int'(tr_r[i].dst) >= N_STATES) begin
          bad_entry = 1'b1;
        end else begin
          has_out[tr_r[i].src] = 1'b1;
        end
      end
    end
  end

  assign cfg_valid = (&has_out) && !bad_entry;

  // A refused table parks the machine in its reset state.
  always_comb begin
    if (!go) begin
      state_nxt = RST_ONEHOT;
    end else if (sel_found) begin
      state_nxt = ONE_BIT << sel_dst;
    end else if (DEFAULT_HOLD) begin
      state_nxt = state_r;
    end else begin
      state_nxt = RST_ONEHOT;
    end
  end

  // Either reset style; both load only the constant reset state.
  if (SYNC_RESET) begin : g_sync
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        state_r <= RST_ONEHOT;
      end else if (rst_act) begin
        state_r <= RST_ONEHOT;
      end else begin
        state_r <= state_nxt;
      end
    end
  end else begin : g_async
    always_ff @(posedge hclk or negedge hresetn or posedge rst_act) begin
      if (!hresetn) begin
        state_r <= RST_ONEHOT;
      end else if (rst_act) begin
        state_r <= RST_ONEHOT;
      end else begin
        state_r <= state_nxt;
      end
    end
  end

  // Output actions; an output without one simply mirrors its state bit.
  for (genvar s = 0; s < N_STATES; s++) begin : g_out
    cond_term #(.N_INPUTS(N_INPUTS), .IN_W(IN_W)) u_act (
      .term    (act_r[s]),
      .in_vals (fsm_in),
      .hit     (act_hit[s])
    );
    assign out_comb[s] = act_en_r[s] ? act_hit[s] : state_r[s];
  end

  // Registering adds a cycle of delay but frees the outputs of glitches.
  if (REG_OUTPUTS) begin : g_oreg
    logic [N_STATES-1:0] out_r;
    if (SYNC_RESET) begin : g_s
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          out_r <= RST_ONEHOT;
        end else if (rst_act) begin
          out_r <= RST_ONEHOT;
        end else begin
          out_r <= out_comb;
        end
      end
    end else begin : g_a
      always_ff @(posedge hclk or negedge hresetn or posedge rst_act) begin
        if (!hresetn) begin
          out_r <= RST_ONEHOT;
        end else if (rst_act) begin
          out_r <= RST_ONEHOT;
        end else begin
          out_r <= out_comb;
        end
      end
    end
    assign state_out = out_r;
  end else begin : g_ocomb
    assign state_out = out_comb;
  end

  // Read multiplexer, evaluated on the address phase address.
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (haddr[7:0])
      `CTRL_OFS:   rd_nxt[`CTRL_RUN_BIT] = run_r;
      `STATUS_OFS: begin
        rd_nxt[N_STATES-1:0]      = state_r;
        rd_nxt[`STATUS_VALID_BIT] = cfg_valid;
      end
      `ACT_EN_OFS: rd_nxt[7:0] = act_en_r;
      default:     rd_nxt = 32'h0000_0000;
    endcase
    for (int k = 0; k < 8; k++) begin
      if (haddr[7:0] == 8'(`ACT_BASE + 4 * k)) begin
        rd_nxt[15:0] = act_r[k];
      end
    end
    for (int i = 0; i < N_TRANS; i++) begin
      if (haddr[7:0] == 8'(`TRANS_BASE + `TRANS_STRIDE * i)) begin
        rd_nxt[`TR_VALID_BIT]      = tr_r[i].valid;
        rd_nxt[`TR_JOIN_BIT]       = tr_r[i].join_or;
        rd_nxt[`TR_SRC_LSB +: 3]   = tr_r[i].src;
        rd_nxt[`TR_DST_LSB +: 3]   = tr_r[i].dst;
      end
      if (haddr[7:0] == 8'(`TRANS_BASE + `TRANS_STRIDE * i + 4)) begin
        rd_nxt = {tr_r[i].t1, tr_r[i].t0};
      end
    end
  end

  // Checks on the state register and outputs.
  chk_state_onehot: assert property (@(posedge hclk) disable iff (!hresetn)
    $onehot(state_r)) else $error("state register is not one-hot");

  chk_reset_entry: assert property (@(posedge hclk) disable iff (!hresetn)
    rst_act ##1 rst_act |-> state_r == RST_ONEHOT) else $error("reset state not entered");

  chk_default_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    DEFAULT_HOLD && go && !sel_found && !rst_act ##1 !rst_act |-> $stable(state_r))
    else $error("state moved with no true condition");

  chk_first_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    go && fire[0] && !rst_act ##1 !rst_act |-> state_r == (ONE_BIT << $past(tr_r[0].dst)))
    else $error("earlier entry did not take priority");

  chk_refused_park: assert property (@(posedge hclk) disable iff (!hresetn)
    !cfg_valid ##1 !cfg_valid |-> state_r == RST_ONEHOT)
    else $error("machine ran with an invalid table");

  chk_move_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    DEFAULT_HOLD && !rst_act && !$past(rst_act) && $past(go) && (state_r != $past(state_r))
    |-> $past(sel_found)) else $error("state changed without a true transition");

  chk_out_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
    !REG_OUTPUTS && act_en_r == 8'h00 |-> state_out == state_r)
    else $error("outputs do not follow the state");

  chk_out_reg: assert property (@(posedge hclk) disable iff (!hresetn)
    REG_OUTPUTS && !rst_act ##1 !rst_act |-> state_out == $past(out_comb))
    else $error("registered outputs lag wrongly");

endmodule // onehot_fsm
`default_nettype wire

// File: onehot_fsm_cfg.svh
`ifndef ONEHOT_FSM_CFG_SVH
`define ONEHOT_FSM_CFG_SVH

// Register byte offsets on the bus.
`define CTRL_OFS      8'h00
`define STATUS_OFS    8'h04
`define ACT_EN_OFS    8'h08
`define ACT_BASE      8'h20
`define TRANS_BASE    8'h40
`define TRANS_STRIDE  8'h08

// Field positions.
`define CTRL_RUN_BIT     0
`define STATUS_VALID_BIT 16
`define TR_VALID_BIT     0
`define TR_JOIN_BIT      1
`define TR_SRC_LSB       4
`define TR_DST_LSB       8
`define TR_T1_LSB        16

// Reset values.
`define RUN_RST    1'b0
`define ACT_EN_RST 8'h00
`define TERM_RST   16'h0000

`endif

// File: onehot_fsm_pkg.sv
`default_nettype none
package onehot_fsm_pkg;

  // Comparison operator of one condition term.
  typedef enum logic [2:0] {
    OP_EQ    = 3'b000,
    OP_NE    = 3'b001,
    OP_GT    = 3'b010,
    OP_GE    = 3'b011,
    OP_LT    = 3'b100,
    OP_LE    = 3'b101,
    OP_TRUE  = 3'b110,
    OP_FALSE = 3'b111
  } op_t;

  // One comparison term, 16 bits, as laid out in the register word.
  typedef struct packed {
    logic [7:0] b_val;   // Immediate (signed) or input index in low bits.
    logic       b_imm;   // Right operand is the immediate.
    logic       neg_a;   // Arithmetic negation of the left operand.
    op_t        op;      // Comparison.
    logic [2:0] a_sel;   // Left operand input index.
  } term_t;

  // One transition entry.
  typedef struct packed {
    logic       valid;
    logic       join_or; // Terms joined by OR when set, AND when clear.
    logic [2:0] src;
    logic [2:0] dst;
    term_t      t0;
    term_t      t1;
  } trans_t;

endpackage
`default_nettype wire

// File: cond_term.sv
`default_nettype none
module cond_term #(
  parameter int N_INPUTS = 5,
  parameter int IN_W     = 26
) (
  input  wire onehot_fsm_pkg::term_t                 term,    // Term to evaluate.
  input  wire logic [N_INPUTS-1:0][IN_W-1:0]         in_vals, // Surrounding inputs.
  output logic                                       hit      // Term is true.
);
  import onehot_fsm_pkg::*;

  localparam int OW = IN_W + 1;

  // One extra bit keeps the negation of the most negative input exact.
  logic              a_ok;
  logic              b_ok;
  logic signed [OW-1:0] a_raw;
  logic signed [OW-1:0] a_op;
  logic signed [OW-1:0] b_op;

  // Out-of-range input indices read as zero rather than as unknowns.
  assign a_ok  = int'(term.a_sel) < N_INPUTS;
  assign b_ok  = int'(term.b_val[2:0]) < N_INPUTS;
  assign a_raw = a_ok ? OW'($signed(in_vals[term.a_sel])) : '0;
  assign a_op  = term.neg_a ? -a_raw : a_raw;
  assign b_op  = term.b_imm ? OW'($signed(term.b_val)) :
                 (b_ok ? OW'($signed(in_vals[term.b_val[2:0]])) : '0);

  // Negation binds first, then the single comparison.
  always_comb begin
    case (term.op)
      OP_EQ:    hit = (a_op == b_op);
      OP_NE:    hit = (a_op != b_op);
      OP_GT:    hit = (a_op > b_op);
      OP_GE:    hit = (a_op >= b_op);
      OP_LT:    hit = (a_op < b_op);
      OP_LE:    hit = (a_op <= b_op);
      OP_TRUE:  hit = 1'b1;
      default:  hit = 1'b0;
    endcase
  end

endmodule // cond_term
`default_nettype wire

// File: fsm_env_model.sv
`default_nettype none
// Surrounding logic that presents fresh signed integers to the machine.
module fsm_env_model #(
  parameter int N_INPUTS = 5,
  parameter int IN_W     = 26
) (
  input  wire logic                     hclk,  // Machine clock.
  input  wire logic                     en,    // New values each edge when high.
  output logic [N_INPUTS-1:0][IN_W-1:0] fsm_in // Integer inputs.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] st_r;
  // Half the values are small so equality terms really fire.
  // Large values stay well inside two to the 25th in magnitude.
  initial begin
    st_r = 32'h00001D3B;
    fsm_in = '0;
  end
  // One new value per input after every rising edge with en high.
  always @(posedge hclk) begin
    if (en) begin
      for (int i = 0; i < N_INPUTS; i++) begin
        st_r = st_r ^ (st_r << 13);
        st_r = st_r ^ (st_r >> 17);
        st_r = st_r ^ (st_r << 5);
        fsm_in[i] <= st_r[31] ? IN_W'($signed(st_r[23:0])) : IN_W'($signed(st_r[3:0]));
      end
    end
  end
endmodule // fsm_env_model
`default_nettype wire

// File: tb_configurable_one_hot_fsm.sv
`include "onehot_fsm_cfg.svh"
`default_nettype none
module tb_configurable_one_hot_fsm;
  import onehot_fsm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic             hclk, hresetn, hsel, hwrite, fsm_rst, env_en, run_m, tv_m, chk_on;
  logic [31:0]      haddr, hwdata, rd, seed;
  logic [1:0]       htrans;
  logic [2:0]       hsize, exp_s, exp_s2;
  logic [4:0]       act_en, exp_o2;
  wire logic        hreadyout, hresp;
  wire logic [31:0] hrdata;
  wire logic [4:0]  state_out;
  wire logic [4:0]  state_out2;
  wire logic [4:0][25:0] fsm_in;
  trans_t           tab [8];
  term_t            act [5];
  int               n_errors, checks_done;

  onehot_fsm uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fsm_rst(fsm_rst),
    .fsm_in(fsm_in), .state_out(state_out));
  fsm_env_model env (.hclk(hclk), .en(env_en), .fsm_in(fsm_in));

  // Second build: reset taken at the edge and active low, registered outputs, no hold.
  onehot_fsm #(.SYNC_RESET(1'b1), .RESET_ACTIVE_HIGH(1'b0), .REG_OUTPUTS(1'b1),
    .DEFAULT_HOLD(1'b0)) uut2 (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(), .hresp(), .hrdata(), .fsm_rst(~fsm_rst),
    .fsm_in(fsm_in), .state_out(state_out2));

  // Clock at 20 MHz.
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Xorshift generator; the seed starts at 69 so every run repeats.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Reference evaluation of one term, signed over one bit more than the inputs.
  function automatic logic ev(input term_t t, input logic [4:0][25:0] v);
    logic signed [26:0] a, b;
    a = (t.a_sel < 3'h5) ? {v[t.a_sel][25], v[t.a_sel]} : 27'h0;
    if (t.neg_a) a = -a;
    b = (t.b_val[2:0] < 3'h5) ? {v[t.b_val[2:0]][25], v[t.b_val[2:0]]} : 27'h0;
    if (t.b_imm) b = {{19{t.b_val[7]}}, t.b_val};
    case (t.op)
      OP_EQ:   return a == b;
      OP_NE:   return a != b;
      OP_GT:   return a > b;
      OP_GE:   return a >= b;
      OP_LT:   return a < b;
      OP_LE:   return a <= b;
      OP_TRUE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Earliest true entry out of the state wins; with none it holds or falls back to state 0.
  function automatic logic [2:0] nxt(input logic [2:0] s, input logic [4:0][25:0] v,
                                     input logic hold);
    logic h0, h1;
    for (int i = 0; i < 8; i++) begin
      h0 = ev(tab[i].t0, v);
      h1 = ev(tab[i].t1, v);
      if (tab[i].valid && tab[i].src == s && (tab[i].join_or ? (h0 | h1) : (h0 & h1)))
        return tab[i].dst;
    end
    return hold ? s : 3'h0;
  endfunction

  // One-hot state with any enabled action terms laid over it.
  function automatic logic [4:0] exp_out(input logic [2:0] s, input logic [4:0][25:0] v);
    logic [4:0] o;
    o = 5'h01 << s;
    for (int k = 0; k < 5; k++) if (act_en[k]) o[k] = ev(act[k], v);
    return o;
  endfunction

  task automatic print_verdict();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // Waits for hready high at a rising edge, bounded.
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready_ok() == 1'b0 && n < 100);
    if (!hready_ok()) begin
      n_errors++;
      print_verdict();
    end
  endtask

  function automatic logic hready_ok();
    return hreadyout === 1'b1;
  endfunction

  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    hsize <= 3'b010;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  function automatic term_t rterm(input logic [2:0] op);
    logic [31:0] x;
    term_t t;
    x = rnd();
    t = term_t'(x[15:0]);
    t.op = op_t'(op);
    if (t.b_imm) t.b_val = {{5{x[20]}}, x[20:18]};
    return t;
  endfunction

  // Loads a random table in which every state has an outgoing entry.
  task automatic load_table(input int tno);
    logic [31:0] x;
    for (int i = 0; i < 8; i++) begin
      x = rnd();
      tab[i].valid = 1'b1;
      tab[i].join_or = x[0];
      tab[i].src = (i < 5) ? 3'(i) : 3'(x[7:4] % 5);
      tab[i].dst = 3'(x[11:8] % 5);
      tab[i].t0 = rterm(tno == 0 ? 3'(i) : x[14:12]);
      tab[i].t1 = rterm(x[17:15]);
      bus(1'b1, `TRANS_BASE + 8'(8 * i),
          {21'h0, tab[i].dst, 1'b0, tab[i].src, 2'b00, tab[i].join_or, 1'b1});
      bus(1'b1, `TRANS_BASE + 8'(8 * i) + 8'h04, {tab[i].t1, tab[i].t0});
    end
    for (int k = 0; k < 5; k++) begin
      act[k] = rterm(x[20 + k -: 3]);
      bus(1'b1, `ACT_BASE + 8'(4 * k), {16'h0, act[k]});
    end
    x = rnd();
    bus(1'b1, `ACT_EN_OFS, {24'h0, x[7:0]});
    act_en = x[4:0];
    bus(1'b0, `TRANS_BASE + 8'h18, 32'h0);
    check(rd, {21'h0, tab[3].dst, 1'b0, tab[3].src, 2'b00, tab[3].join_or, 1'b1});
  endtask

  // Reference state, stepped on the same edges as the machine.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) exp_s <= 3'h0;
    else if (fsm_rst || !(run_m && tv_m)) exp_s <= 3'h0;
    else exp_s <= nxt(exp_s, fsm_in, 1'b1);
  end

  // Reference for the second build: reset seen at the edge, outputs one edge late.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exp_s2 <= 3'h0;
      exp_o2 <= 5'h01;
    end else if (fsm_rst) begin
      exp_s2 <= 3'h0;
      exp_o2 <= 5'h01;
    end else begin
      exp_s2 <= (run_m && tv_m) ? nxt(exp_s2, fsm_in, 1'b0) : 3'h0;
      exp_o2 <= exp_out(exp_s2, fsm_in);
    end
  end

  // Outputs are compared mid-cycle, when inputs and state have settled.
  always @(negedge hclk) begin
    if (chk_on) begin
      check(state_out, exp_out(fsm_rst ? 3'h0 : exp_s, fsm_in));
      check(state_out2, exp_o2);
    end
  end

  initial begin
    seed = 32'h00000045;
    {hresetn, fsm_rst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    {env_en, run_m, chk_on, act_en} = '0;
    tv_m = 1'b1;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(state_out, 32'h01);
    bus(1'b0, `STATUS_OFS, 32'h0);
    check(rd, 32'h00000001);
    bus(1'b1, 8'h14, 32'hFFFFFFFF);
    bus(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0);
    env_en <= 1'b1;
    for (int t = 0; t < 3; t++) begin
      chk_on <= 1'b0;
      bus(1'b1, `CTRL_OFS, 32'h0);
      run_m <= 1'b0;
      load_table(t);
      bus(1'b0, `STATUS_OFS, 32'h0);
      check(rd[16], 1'b1);
      bus(1'b1, `CTRL_OFS, 32'h1);
      run_m <= 1'b1;
      chk_on <= 1'b1;
      repeat (60) @(posedge hclk);
      fsm_rst <= 1'b1;
      repeat (3) @(posedge hclk);
      fsm_rst <= 1'b0;
      repeat (30) @(posedge hclk);
    end
    // A table where state 4 has no way out must not run.
    chk_on <= 1'b0;
    for (int i = 0; i < 8; i++) if (tab[i].src == 3'h4) bus(1'b1, `TRANS_BASE + 8'(8 * i), 32'h0);
    tv_m <= 1'b0;
    repeat (2) @(posedge hclk);
    chk_on <= 1'b1;
    repeat (20) @(posedge hclk);
    bus(1'b0, `STATUS_OFS, 32'h0);
    check(rd[16], 1'b0);
    print_verdict();
  end
endmodule // tb_configurable_one_hot_fsm
`default_nettype wire
